// >>> design/tswo_wave_out.v
// eight-channel toggle and set/reset waveform output with base counter
`timescale 1ns/1ns
`default_nettype none
`include "tswo_regs.vh"
module tswo_wave_out #(
  parameter NCH = `TSWO_NUM_CHAN,
  parameter CW = `TSWO_CNT_W
) (
  input wire clock_in,
  input wire rst_in,
  input wire ce_in,
  input wire count_clock_in,
  input wire [2:0] base_reset_sel_in,
  input wire [CW-1:0] period_reset_value_in,
  input wire cmp_wr_in,
  input wire [2:0] cmp_addr_in,
  input wire [CW-1:0] cmp_data_in,
  input wire [NCH*`TSWO_CTRL_W-1:0] wave_ctrl_in,
  input wire [NCH-1:0] chan_enable_set_in,
  input wire [NCH-1:0] flag_clear_in,
  output reg [CW-1:0] base_count_out,
  output reg [NCH-1:0] match_request_flags_out,
  output reg [NCH-1:0] wave_out_pin_out,
  output wire [NCH-1:0] wave_out_en_out
);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function [1:0] mode_of;
    input [NCH*`TSWO_CTRL_W-1:0] ctrl;
    input integer ch;
    begin
      mode_of = ctrl[ch*`TSWO_CTRL_W+`TSWO_CTRL_MODE_LSB +: 2];
    end
  endfunction

  function ctrl_bit;
    input [NCH*`TSWO_CTRL_W-1:0] ctrl;
    input integer ch;
    input integer pos;
    begin
      ctrl_bit = ctrl[ch*`TSWO_CTRL_W+pos];
    end
  endfunction

  function is_even;
    input integer ch;
    begin
      is_even = (ch % 2 == 0);
    end
  endfunction

  function integer even_of;
    input integer ch;
    begin
      even_of = ch - (ch % 2);
    end
  endfunction

  // a set/reset pair needs both of its channel enables
  function pair_enabled;
    input [NCH-1:0] en;
    input integer ev;
    begin
      pair_enabled = en[ev] & en[ev+1];
    end
  endfunction

  function [CW-1:0] cmp_of;
    input [CW*NCH-1:0] all;
    input integer ch;
    begin
      cmp_of = all[ch*CW +: CW];
    end
  endfunction

  // --------------------------------------------------------------
  // count clock synchroniser and tick
  // --------------------------------------------------------------
  reg cc_meta;
  reg cc_sync;
  reg cc_last;
  wire tick;
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cc_meta <= 1'b0;
      cc_sync <= 1'b0;
      cc_last <= 1'b0;
    end else if (ce_in) begin
      cc_meta <= count_clock_in;
      cc_sync <= cc_meta;
      cc_last <= cc_sync;
    end
  end
  assign tick = ce_in & cc_sync & ~cc_last;

  // --------------------------------------------------------------
  // compare values
  // --------------------------------------------------------------
  wire [CW*NCH-1:0] cmp_all;
  tswo_compare_ram #(
    .WIDTH(CW),
    .DEPTH(NCH),
    .AW(3)
  ) u_cmp (
    .clock_in(clock_in),
    .ce_in(ce_in),
    .wr_en_in(cmp_wr_in),
    .wr_addr_in(cmp_addr_in),
    .wr_data_in(cmp_data_in),
    .rd_data_out(cmp_all)
  );

  // --------------------------------------------------------------
  // base counter with clear on match
  // --------------------------------------------------------------
  reg [1:0] clr_pend;
  reg [1:0] next_clr_pend;
  reg [CW-1:0] next_count;
  wire sel_ch0 = (base_reset_sel_in == `TSWO_RST_CH0);
  wire sel_per = (base_reset_sel_in == `TSWO_RST_PERIOD);
  wire [CW-1:0] reset_target = sel_per ? period_reset_value_in : cmp_of(cmp_all, 0);
  wire reset_hit = (sel_ch0 | sel_per) && (base_count_out == reset_target);

  // match then one more count before zero, giving period n+2
  always @* begin
    next_count = base_count_out + {{(CW-1){1'b0}}, 1'b1};
    next_clr_pend = 2'h0;
    if (clr_pend == 2'h1) begin
      next_count = `TSWO_CNT_RESET;
    end else if (clr_pend != 2'h0) begin
      next_clr_pend = clr_pend - 2'h1;
    end else if (reset_hit) begin
      next_clr_pend = `TSWO_CLEAR_DELAY - 2'h1;
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      base_count_out <= `TSWO_CNT_RESET;
      clr_pend <= 2'h0;
    end else if (tick) begin
      base_count_out <= next_count;
      clr_pend <= next_clr_pend;
    end
  end

  // --------------------------------------------------------------
  // per-channel mode decode and pin enables
  // --------------------------------------------------------------
  reg [NCH-1:0] wave;
  reg [NCH-1:0] was_en;
  reg [NCH-1:0] match;
  reg [NCH-1:0] active;
  reg [NCH-1:0] is_phase;
  reg [NCH-1:0] next_wave;
  reg [NCH-1:0] next_flags;
  reg [NCH-1:0] next_pin;
  reg [NCH-1:0] pin_en;
  integer c;
  integer ev;
  integer p;
  integer ew;
  integer q;

  always @* begin
    match = {NCH{1'b0}};
    active = {NCH{1'b0}};
    pin_en = {NCH{1'b0}};
    is_phase = {NCH{1'b0}};
    ev = 0;
    for (c = 0; c < NCH; c = c + 1) begin
      ev = even_of(c);
      match[c] = (base_count_out == cmp_of(cmp_all, c));
      case (mode_of(wave_ctrl_in, c))
        `TSWO_MODE_PHASE: begin
          is_phase[c] = 1'b1;
          active[c] = chan_enable_set_in[c];
          pin_en[c] = active[c];
        end
        `TSWO_MODE_SETRESET: begin
          // pair runs only with both enables; pair 0/1 barred when ch0 clears
          active[c] = pair_enabled(chan_enable_set_in, ev) &
            ~(ev == 0 && sel_ch0);
          pin_en[c] = active[c] & is_even(c);
        end
        default: begin
          active[c] = 1'b0;
          pin_en[c] = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // waveform state and request flags
  // --------------------------------------------------------------
  // odd match clears its even partner, only once that partner is running
  always @* begin
    next_wave = wave;
    next_flags = match_request_flags_out & ~flag_clear_in;
    ew = 0;
    for (p = 0; p < NCH; p = p + 1) begin
      ew = even_of(p);
      if (!active[p] || !was_en[p]) begin
        next_wave[p] = ctrl_bit(wave_ctrl_in, p, `TSWO_CTRL_IVL_BIT);
      end else if (tick && match[p]) begin
        next_flags[p] = 1'b1;
        if (is_phase[p]) begin
          next_wave[p] = ~wave[p];
        end else if (is_even(p)) begin
          next_wave[p] = 1'b1;
        end else if (active[ew] && was_en[ew]) begin
          next_wave[ew] = 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // pin levels
  // --------------------------------------------------------------
  // computed after every clear above, so the even pin falls on the odd match
  always @* begin
    next_pin = {NCH{1'b0}};
    for (q = 0; q < NCH; q = q + 1) begin
      next_pin[q] = pin_en[q] &
        (next_wave[q] ^ ctrl_bit(wave_ctrl_in, q, `TSWO_CTRL_INV_BIT));
    end
  end

  // --------------------------------------------------------------
  // waveform state registers
  // --------------------------------------------------------------
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wave <= {NCH{1'b0}};
      was_en <= {NCH{1'b0}};
    end else if (ce_in) begin
      wave <= next_wave;
      was_en <= active;
    end
  end

  // --------------------------------------------------------------
  // output registers
  // --------------------------------------------------------------
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      match_request_flags_out <= {NCH{1'b0}};
      wave_out_pin_out <= {NCH{1'b0}};
    end else if (ce_in) begin
      match_request_flags_out <= next_flags;
      wave_out_pin_out <= next_pin;
    end
  end

  // --------------------------------------------------------------
  // output enables
  // --------------------------------------------------------------
  // enables follow mode and enables at once, pins follow one clock later
  assign wave_out_en_out = pin_en;
endmodule
`default_nettype wire

// >>> shared/tswo_regs.vh
// constants of the eight-channel waveform output block
`ifndef TSWO_REGS_VH
`define TSWO_REGS_VH
`define TSWO_NUM_CHAN 8
`define TSWO_CNT_W 16
`define TSWO_CNT_RESET 16'h0000
`define TSWO_CNT_MAX 16'hFFFF
`define TSWO_MODE_SINGLE 2'h0
`define TSWO_MODE_SETRESET 2'h1
`define TSWO_MODE_PHASE 2'h2
`define TSWO_CLEAR_DELAY 2'h2
`define TSWO_RST_CH0 3'h1
`define TSWO_RST_PERIOD 3'h4
`define TSWO_CTRL_MODE_LSB 0
`define TSWO_CTRL_IVL_BIT 2
`define TSWO_CTRL_INV_BIT 3
`define TSWO_CTRL_W 4
`endif

// >>> design/tswo_compare_ram.v
// compare value store, one word per channel, combinational read
`timescale 1ns/1ns
`default_nettype none
module tswo_compare_ram #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock_in,
  input wire ce_in,
  input wire wr_en_in,
  input wire [AW-1:0] wr_addr_in,
  input wire [WIDTH-1:0] wr_data_in,
  output wire [WIDTH*DEPTH-1:0] rd_data_out
);
  reg [WIDTH*DEPTH-1:0] mem;
  integer i;
  always @(posedge clock_in) begin
    if (ce_in && wr_en_in) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (wr_addr_in == i[AW-1:0]) begin
          mem[i*WIDTH +: WIDTH] <= wr_data_in;
        end
      end
    end
  end
  assign rd_data_out = mem;
endmodule
`default_nettype wire

// >>> tb/tswo_wave_out_props.sv
// assertion checker for the waveform output block
`timescale 1ns/1ns
`default_nettype none
module tswo_wave_out_props #(parameter NCH = 8, parameter CW = 16) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [2:0] base_reset_sel_in,
  input wire logic [CW-1:0] period_reset_value_in,
  input wire logic [NCH*4-1:0] wave_ctrl_in,
  input wire logic [NCH-1:0] chan_enable_set_in,
  input wire logic [NCH-1:0] flag_clear_in,
  input wire logic [CW-1:0] base_count_out,
  input wire logic [NCH-1:0] match_request_flags_out,
  input wire logic [NCH-1:0] wave_out_en_out
);
  logic [NCH-1:0] sr_m;
  logic [NCH-1:0] drv_m;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      sr_m[i] = wave_ctrl_in[4*i +: 2] == 2'h1;
      drv_m[i] = sr_m[i] || wave_ctrl_in[4*i +: 2] == 2'h2;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_count_step: assert property ($changed(base_count_out) |-> base_count_out == 16'h0
    || base_count_out == $past(base_count_out) + 16'h1) else $error("counter jumped");
  a_period_clear: assert property (base_reset_sel_in == 3'h4 && $changed(base_count_out)
    && $past(base_count_out) == period_reset_value_in + 16'h1 |-> base_count_out == 16'h0)
    else $error("counter missed period clear");
  a_flag_sticky: assert property ((~match_request_flags_out & $past(match_request_flags_out)
    & ~$past(flag_clear_in)) == 8'h0) else $error("flag fell without clear");
  a_odd_sr_off: assert property ((wave_out_en_out & sr_m & 8'hAA) == 8'h0)
    else $error("odd pin driven in set/reset");
  a_mode_off: assert property ((wave_out_en_out & ~drv_m) == 8'h0)
    else $error("pin driven in undriven mode");
  a_disabled_off: assert property ((wave_out_en_out & ~chan_enable_set_in) == 8'h0)
    else $error("disabled pin driven");
  a_pair_needs_odd: assert property ((wave_out_en_out & sr_m & 8'h55
    & ~(chan_enable_set_in >> 1)) == 8'h0) else $error("pair runs without odd enable");
  a_pair01_off: assert property (base_reset_sel_in == 3'h1 && sr_m[0] |-> !wave_out_en_out[0])
    else $error("pair 0/1 runs while channel 0 clears counter");
endmodule
bind tswo_wave_out tswo_wave_out_props #(.NCH(NCH), .CW(CW)) u_props (.clock_in(clock_in),
  .rst_in(rst_in), .base_reset_sel_in(base_reset_sel_in),
  .period_reset_value_in(period_reset_value_in), .wave_ctrl_in(wave_ctrl_in),
  .chan_enable_set_in(chan_enable_set_in), .flag_clear_in(flag_clear_in),
  .base_count_out(base_count_out), .match_request_flags_out(match_request_flags_out),
  .wave_out_en_out(wave_out_en_out));
`default_nettype wire

// >>> tb/tswo_pin_load.sv
// external load that times high level and period of each pin
`timescale 1ns/1ns
`default_nettype none
module tswo_pin_load (
  input wire logic clock_in,
  input wire logic [7:0] pin_in,
  output logic [15:0] hi_len_out [8],
  output logic [15:0] per_len_out [8]
);
  logic [7:0] last = 8'h00;
  logic [15:0] hi [8] = '{default: 16'h0};
  logic [15:0] per [8] = '{default: 16'h0};
  always @(posedge clock_in) begin
    last <= pin_in;
    for (int i = 0; i < 8; i++) begin
      hi[i] <= pin_in[i] ? hi[i] + 16'h1 : 16'h0;
      per[i] <= (pin_in[i] && !last[i]) ? 16'h1 : per[i] + 16'h1;
      if (!pin_in[i] && last[i]) hi_len_out[i] <= hi[i];
      if (pin_in[i] && !last[i]) per_len_out[i] <= per[i];
    end
  end
endmodule
`default_nettype wire

// >>> tb/tswo_wave_out_tb.sv
// self-checking testbench for the waveform output block
`timescale 1ns/1ns
`default_nettype none
module tswo_wave_out_tb;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic count_clock_in = 1'b0;
  logic cmp_wr_in = 1'b0;
  logic [2:0] base_reset_sel_in = 3'h4;
  logic [2:0] cmp_addr_in = 3'h0;
  logic [15:0] period_reset_value_in = 16'h0006;
  logic [15:0] cmp_data_in = 16'h0000;
  logic [31:0] wave_ctrl_in = 32'h0;
  logic [7:0] chan_enable_set_in = 8'h00;
  logic [7:0] flag_clear_in = 8'h00;
  logic [1:0] div = 2'h0;
  wire [15:0] cnt;
  wire [7:0] flags, pins, ens;
  logic [15:0] hi_len [8];
  logic [15:0] per_len [8];
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  tswo_wave_out u_dut (.clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1),
    .count_clock_in(count_clock_in), .base_reset_sel_in(base_reset_sel_in),
    .period_reset_value_in(period_reset_value_in), .cmp_wr_in(cmp_wr_in),
    .cmp_addr_in(cmp_addr_in), .cmp_data_in(cmp_data_in), .wave_ctrl_in(wave_ctrl_in),
    .chan_enable_set_in(chan_enable_set_in), .flag_clear_in(flag_clear_in),
    .base_count_out(cnt), .match_request_flags_out(flags), .wave_out_pin_out(pins),
    .wave_out_en_out(ens));
  tswo_pin_load u_load (.clock_in(clock_in), .pin_in(pins), .hi_len_out(hi_len),
    .per_len_out(per_len));
  initial forever #5 clock_in = ~clock_in;
  // count clock: two cycles high, two low
  always @(posedge clock_in) begin
    div <= div + 2'h1;
    count_clock_in <= div[1];
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      summarize;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock_in);
    cmp_wr_in <= 1'b1;
    cmp_addr_in <= a;
    cmp_data_in <= d;
    @(posedge clock_in);
    cmp_wr_in <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic t_phase;
    wr(3'h2, 16'h0003);
    wr(3'h1, 16'hFFF0);
    wr(3'h3, 16'hFFF0);
    wr(3'h4, 16'hFFF0);
    @(posedge clock_in);
    wave_ctrl_in <= 32'h000E_A260;
    chan_enable_set_in <= 8'h1E;
    wt(400);
    check(hi_len[2], 16'h0020);
    check(per_len[2], 16'h0040);
    check(16'({pins[4:3], pins[1]}), 16'h0003);
    check(16'(pins[1]), 16'h0001);
    check(16'(flags[2:1]), 16'h0002);
    @(posedge clock_in);
    chan_enable_set_in <= 8'h00;
    wt(4);
    check({ens, pins}, 16'h0000);
  endtask
  task automatic t_sr;
    wr(3'h6, 16'h0002);
    wr(3'h7, 16'h0005);
    @(posedge clock_in);
    flag_clear_in <= 8'hFF;
    wave_ctrl_in <= 32'h1100_0000;
    chan_enable_set_in <= 8'hC0;
    @(posedge clock_in);
    flag_clear_in <= 8'h00;
    wt(400);
    check(hi_len[6], 16'h000C);
    check(per_len[6], 16'h0020);
    check(16'(ens[7:6]), 16'h0001);
    check(16'(flags[7:6]), 16'h0003);
    @(posedge clock_in);
    chan_enable_set_in <= 8'h40;
    wt(4);
    check(16'(ens[6]), 16'h0000);
  endtask
  task automatic t_pair0;
    @(posedge clock_in);
    base_reset_sel_in <= 3'h1;
    wr(3'h0, 16'h0006);
    wr(3'h1, 16'h0009);
    @(posedge clock_in);
    wave_ctrl_in <= 32'h0000_0011;
    chan_enable_set_in <= 8'h03;
    wt(40);
    check(16'(ens[0]), 16'h0000);
  endtask
  initial begin
    #1;
    check({cnt[7:0], flags | pins}, 16'h0000);
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    t_phase;
    t_sr;
    t_pair0;
    summarize;
  end
endmodule
`default_nettype wire
